// >>> core/bus_event_timer.v
// bus-event condition qualifier, 128 us ticks
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"
module bus_event_timer #(
	parameter TICK_CYC = `BUS_TICK_CYC
) (
	input  wire clock,
	input  wire rst_n,
	input  wire cond,
	output reg  event_pulse
);
	reg [15:0] tick_cnt_reg;
	reg        tick_reg;
	reg [1:0]  seen_reg;
	// free-running tick: condition must span two ticks, i.e. 128 to 256 us
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b0;
			seen_reg     <= 2'h0;
			event_pulse  <= 1'b0;
		end else begin
			tick_reg    <= (tick_cnt_reg == TICK_CYC - 1);
			event_pulse <= 1'b0;
			if (tick_cnt_reg == TICK_CYC - 1)
				tick_cnt_reg <= 16'h0000;
			else
				tick_cnt_reg <= tick_cnt_reg + 16'h0001;
			if (!cond)
				seen_reg <= 2'h0;
			else if (tick_reg) begin
				if (seen_reg == 2'h1)
					event_pulse <= 1'b1;
				if (seen_reg != 2'h2)
					seen_reg <= seen_reg + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> core/irq_ctrl_regs.vh
// constants for the interrupt controller and core status/control register
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH
`define STATUS_ADDR      8'hff
`define GIE_ADDR         8'h20
`define EPIE_ADDR        8'h21
`define STATUS_RESET     8'h11
`define STATUS_DOG_RESET 8'h41
`define BIT_PEND         7
`define BIT_DOG          6
`define BIT_BUS          5
`define BIT_SUPPLY       4
`define BIT_SUSP         3
`define BIT_SENSE        2
`define BIT_RUN          0
`define VEC_BASE         16'h0002
`define VEC_RESET        16'h0000
`define CALL_CYCLES      10
`define JUMP_CYCLES      5
`define BUS_TICK_NS      128000
`define CLK_NS           100
`define BUS_TICK_CYC     (`BUS_TICK_NS / `CLK_NS)
`define NUM_SRC          11
`endif

// >>> core/irq_ctrl_status_reg.v
// interrupt controller and core status/control register
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"
module irq_ctrl_status_reg #(
	parameter TICK_CYC = `BUS_TICK_CYC
) (
	input  wire        clock,
	input  wire        rstn,
	input  wire        low_supply_reset,
	input  wire        supply_dip_reset,
	input  wire        dog_timeout_reset,
	input  wire [7:0]  io_addr,
	input  wire [7:0]  io_wdata,
	input  wire        port_write_op,
	input  wire        io_rd,
	output reg  [7:0]  io_rdata,
	input  wire        instr_end,
	input  wire        mask_all_instr,
	input  wire        unmask_all_instr,
	input  wire        return_from_handler_op,
	input  wire        stop_core_op,
	input  wire [15:0] pc_in,
	input  wire        carry_flag,
	input  wire        zero_flag,
	input  wire        usb_ps2_mode,
	input  wire        usb_se0,
	input  wire        ps2_data_low,
	input  wire        bus_activity,
	input  wire [10:0] src_event,
	output reg         ack_start,
	output reg         call_push,
	output reg  [17:0] push_word,
	output reg         vec_valid,
	output reg  [15:0] vec_addr,
	output reg         core_halt,
	output reg         suspended,
	output reg         restore_en
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_CALL = 4'b0010;
	localparam ST_JUMP = 4'b0100;
	localparam ST_HOLD = 4'b1000;
	localparam [10:0] LIVE = 11'b110_0001_1111;
	reg        r1_reg;
	reg        rst_n;
	reg [2:0]  rs_a_reg;
	reg [2:0]  rs_b_reg;
	reg [10:0] bus_a_reg;
	reg [10:0] bus_b_reg;
	reg        se0_a_reg;
	reg        se0_b_reg;
	reg        ps2_a_reg;
	reg        ps2_b_reg;
	reg        act_a_reg;
	reg        act_b_reg;
	reg [10:0] pend_reg;
	reg [7:0]  gie_reg;
	reg [2:0]  epie_reg;
	reg        genable_reg;
	reg        dog_reg;
	reg        bus_reg;
	reg        supply_reg;
	reg        susp_reg;
	reg        run_reg;
	reg [3:0]  state_reg;
	reg [3:0]  cnt_reg;
	reg [3:0]  vnum_reg;
	wire       bus_ev;
	wire       any_req;
	wire [3:0] win_num;
	wire [10:0] enables;
	wire [10:0] req;
	wire       bus_cond;
	wire       any_rst;
	wire [7:0] status_view;
	wire       st_wr;
	function [15:0] vector_of;
		input [3:0] n;
		begin
			vector_of = `VEC_BASE + {11'h000, n - 4'h1, 1'b0};
		end
	endfunction
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r1_reg <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			r1_reg <= 1'b1;
			rst_n  <= r1_reg;
		end
	end
	// pins and reset causes pass through two-flop synchronizers before use
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rs_a_reg  <= 3'h0;
			rs_b_reg  <= 3'h0;
			se0_a_reg <= 1'b0;
			se0_b_reg <= 1'b0;
			ps2_a_reg <= 1'b0;
			ps2_b_reg <= 1'b0;
			act_a_reg <= 1'b0;
			act_b_reg <= 1'b0;
			bus_a_reg <= 11'h000;
			bus_b_reg <= 11'h000;
		end else begin
			rs_a_reg  <= {dog_timeout_reset, supply_dip_reset, low_supply_reset};
			rs_b_reg  <= rs_a_reg;
			se0_a_reg <= usb_se0;
			se0_b_reg <= se0_a_reg;
			ps2_a_reg <= ps2_data_low;
			ps2_b_reg <= ps2_a_reg;
			act_a_reg <= bus_activity;
			act_b_reg <= act_a_reg;
			bus_a_reg <= src_event;
			bus_b_reg <= bus_a_reg;
		end
	end
	assign bus_cond = usb_ps2_mode ? ps2_b_reg : se0_b_reg;
	bus_event_timer #(.TICK_CYC(TICK_CYC)) u_bus_timer (
		.clock       (clock),
		.rst_n       (rst_n),
		.cond        (bus_cond),
		.event_pulse (bus_ev)
	);
	assign enables = {gie_reg[7], gie_reg[6], 4'h0, epie_reg[2] | epie_reg[1], epie_reg[0],
		gie_reg[2], gie_reg[1], gie_reg[0]};
	assign req = pend_reg & enables & LIVE & {11{genable_reg}};
	irq_prio u_prio (
		.req (req),
		.any (any_req),
		.num (win_num)
	);
	assign any_rst = rs_b_reg[0] | rs_b_reg[1] | rs_b_reg[2];
	assign st_wr = port_write_op && io_addr == `STATUS_ADDR;
	// bit 1 reads zero; firmware keeps it zero on write
	assign status_view = {~genable_reg & (|(pend_reg & LIVE)), dog_reg, bus_reg, supply_reg,
		susp_reg, genable_reg, 1'b0, run_reg};
	// pending flops: set wins over acknowledge clear
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= 11'h000;
		end else if (any_rst) begin
			pend_reg <= 11'h000;
		end else begin
			// only the second sync flop is read; a one-cycle event still lands
			pend_reg <= (pend_reg & ~(((instr_end && any_req && state_reg == ST_IDLE
				&& !susp_reg && run_reg) ? 11'h001 : 11'h000) << (win_num - 4'h1)))
				| ({bus_b_reg[10:1], bus_ev} & LIVE);
		end
	end
	// enable registers and global enable
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gie_reg     <= 8'h00;
			epie_reg    <= 3'h0;
			genable_reg <= 1'b0;
		end else if (any_rst) begin
			gie_reg     <= 8'h00;
			epie_reg    <= 3'h0;
			genable_reg <= 1'b0;
		end else begin
			if (port_write_op && io_addr == `GIE_ADDR)
				gie_reg <= io_wdata & 8'hc7;
			if (port_write_op && io_addr == `EPIE_ADDR)
				epie_reg <= io_wdata[2:0];
			if (state_reg == ST_IDLE && instr_end && any_req && !susp_reg && run_reg)
				genable_reg <= 1'b0;
			else if (mask_all_instr)
				genable_reg <= 1'b0;
			else if (unmask_all_instr || return_from_handler_op)
				genable_reg <= 1'b1;
		end
	end
	// status bits and reset causes
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dog_reg    <= 1'b0;
			bus_reg    <= 1'b0;
			supply_reg <= 1'b1;
			susp_reg   <= 1'b0;
			run_reg    <= 1'b1;
		end else if (rs_b_reg[0] || rs_b_reg[1]) begin
			dog_reg    <= 1'b0;
			bus_reg    <= 1'b0;
			supply_reg <= 1'b1;
			susp_reg   <= 1'b0;
			run_reg    <= 1'b1;
		end else if (rs_b_reg[2]) begin
			dog_reg  <= 1'b1;
			susp_reg <= 1'b0;
			run_reg  <= 1'b1;
			bus_reg  <= bus_reg | bus_ev;
		end else begin
			if (st_wr) begin
				bus_reg    <= io_wdata[`BIT_BUS] | bus_ev;
				dog_reg    <= io_wdata[`BIT_DOG];
				supply_reg <= io_wdata[`BIT_SUPPLY];
				run_reg    <= io_wdata[`BIT_RUN] & ~stop_core_op;
			end else begin
				bus_reg <= bus_reg | bus_ev;
				if (stop_core_op)
					run_reg <= 1'b0;
			end
			// suspend entered for at least one cycle even with resume present
			if (st_wr && io_wdata[`BIT_SUSP])
				susp_reg <= 1'b1;
			else if (susp_reg && (act_b_reg || (|(pend_reg & enables & LIVE))))
				susp_reg <= 1'b0;
		end
	end
	// acknowledge sequence: call then jump slot
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg  <= ST_IDLE;
			cnt_reg    <= 4'h0;
			vnum_reg   <= 4'h0;
			ack_start  <= 1'b0;
			call_push  <= 1'b0;
			push_word  <= 18'h00000;
			vec_valid  <= 1'b0;
			vec_addr   <= `VEC_RESET;
			io_rdata   <= 8'h00;
			core_halt  <= 1'b0;
			suspended  <= 1'b0;
			restore_en <= 1'b0;
		end else begin
			ack_start  <= 1'b0;
			call_push  <= 1'b0;
			vec_valid  <= 1'b0;
			restore_en <= return_from_handler_op;
			core_halt  <= ~run_reg | susp_reg | (state_reg != ST_IDLE);
			suspended  <= susp_reg;
			if (any_rst) begin
				state_reg <= ST_IDLE;
				vec_addr  <= `VEC_RESET;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						if (instr_end && any_req && !susp_reg && run_reg) begin
							state_reg <= ST_CALL;
							vnum_reg  <= win_num;
							cnt_reg   <= 4'h0;
							ack_start <= 1'b1;
							call_push <= 1'b1;
							push_word <= {carry_flag, zero_flag, pc_in};
						end
					end
					ST_CALL: begin
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == `CALL_CYCLES - 2) begin
							state_reg <= ST_JUMP;
							vec_valid <= 1'b1;
							vec_addr  <= vector_of(vnum_reg);
							cnt_reg   <= 4'h0;
						end
					end
					ST_JUMP: begin
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == `JUMP_CYCLES - 1)
							state_reg <= ST_HOLD;
					end
					ST_HOLD: state_reg <= ST_IDLE;
					default: state_reg <= ST_IDLE;
				endcase
			end
			if (io_rd) begin
				case (io_addr)
					`STATUS_ADDR: io_rdata <= status_view;
					`GIE_ADDR:    io_rdata <= gie_reg;
					`EPIE_ADDR:   io_rdata <= {5'h00, epie_reg};
					default:      io_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> core/irq_prio.v
// fixed priority picker, lowest index wins
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"
module irq_prio (
	input  wire [10:0] req,
	output reg         any,
	output reg  [3:0]  num
);
	integer i;
	always @* begin
		any = 1'b0;
		num = 4'h0;
		for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				any = 1'b1;
				num = i[3:0] + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/core_model.sv
// processor core stand-in: instruction ends, state words, handler returns
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic        clock,
	input  wire logic        slow,
	input  wire logic        core_halt,
	input  wire logic        suspended,
	input  wire logic        vec_valid,
	output var  logic        instr_end,
	output var  logic        return_from_handler_op,
	output var  logic [15:0] pc_in,
	output var  logic        carry_flag,
	output var  logic        zero_flag
);
	int cnt = 0;
	int ret = 0;
	initial {instr_end, return_from_handler_op, pc_in, carry_flag, zero_flag} = '0;
	always @(posedge clock) begin
		if (vec_valid)
			ret = 8;
		#1;
		instr_end = 0;
		return_from_handler_op = ret == 1;
		if (ret > 0)
			ret--;
		cnt = (cnt + 1) % (slow ? 9 : 3);
		// a halted or sleeping core completes nothing
		if (cnt == 0 && !core_halt && !suspended) begin
			instr_end = 1;
			pc_in = pc_in + 16'h0001;
			{carry_flag, zero_flag} = 2'($urandom);
		end
	end
endmodule
`default_nettype wire

// >>> dv/irq_ctrl_status_reg_assertions.sv
// port-level assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker #(
	parameter TICK_CYC = 4
) (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic [7:0]  io_addr,
	input wire logic [7:0]  io_wdata,
	input wire logic        port_write_op,
	input wire logic        instr_end,
	input wire logic        return_from_handler_op,
	input wire logic [15:0] pc_in,
	input wire logic        carry_flag,
	input wire logic        zero_flag,
	input wire logic        ack_start,
	input wire logic        call_push,
	input wire logic [17:0] push_word,
	input wire logic        vec_valid,
	input wire logic [15:0] vec_addr,
	input wire logic        suspended,
	input wire logic        restore_en
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	ack_call_a: assert property (ack_start |-> call_push)
		else $error("ack without call");
	vec_delay_a: assert property (ack_start |-> ##9 vec_valid)
		else $error("vector not on time");
	vec_range_a: assert property (vec_valid |->
		vec_addr inside {16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h0014, 16'h0016})
		else $error("bad vector");
	push_state_a: assert property (ack_start |->
		push_word == {$past(carry_flag), $past(zero_flag), $past(pc_in)})
		else $error("bad pushed state");
	ack_cause_a: assert property (ack_start |-> $past(instr_end))
		else $error("ack inside instruction");
	ack_single_a: assert property (ack_start |=> !ack_start [*8])
		else $error("overlapping ack");
	restore_ret_a: assert property (return_from_handler_op |=> restore_en)
		else $error("return not restored");
	suspend_entry_a: assert property (port_write_op && io_addr == 8'hff && io_wdata[3]
		|-> ##[1:4] suspended)
		else $error("suspend not entered");
	cover property (vec_valid && vec_addr == 16'h0002);
	cover property (ack_start ##9 vec_valid);
	cover property ($rose(suspended));
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the interrupt controller and status register
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
	localparam TICK_CYC = 4;
	logic        clock = 0, rstn = 0, slow = 0, port_write_op = 0, io_rd = 0;
	logic        low_supply_reset = 0, supply_dip_reset = 0, dog_timeout_reset = 0;
	logic        mask_all_instr = 0, unmask_all_instr = 0, stop_core_op = 0;
	logic        usb_ps2_mode = 0, usb_se0 = 0, ps2_data_low = 0, bus_activity = 0;
	logic        instr_end, return_from_handler_op, carry_flag, zero_flag, ack_start;
	logic        call_push, vec_valid, core_halt, suspended, restore_en;
	logic [7:0]  io_addr = 0, io_wdata = 0, io_rdata;
	logic [15:0] pc_in, vec_addr;
	logic [17:0] push_word;
	logic [10:0] src_event = 0, pend = 0;
	int          err_count = 0, num_checks = 0, gie = 0, i, j, k, m;
	irq_ctrl_status_reg #(.TICK_CYC(TICK_CYC)) irq_ctrl_status_reg_i (.clock, .rstn,
		.low_supply_reset, .supply_dip_reset, .dog_timeout_reset, .io_addr, .io_wdata,
		.port_write_op, .io_rd, .io_rdata, .instr_end, .mask_all_instr, .unmask_all_instr,
		.return_from_handler_op, .stop_core_op, .pc_in, .carry_flag, .zero_flag,
		.usb_ps2_mode, .usb_se0, .ps2_data_low, .bus_activity, .src_event, .ack_start,
		.call_push, .push_word, .vec_valid, .vec_addr, .core_halt, .suspended, .restore_en);
	core_model core_model_i (.clock, .slow, .core_halt, .suspended, .vec_valid, .instr_end,
		.return_from_handler_op, .pc_in, .carry_flag, .zero_flag);
	always #50 clock = ~clock;
	// reference: global enable and pending set, lowest pending index wins
	always @(posedge clock) begin
		if (unmask_all_instr || restore_en)
			gie = 1;
		if (mask_all_instr || ack_start)
			gie = 0;
		if (vec_valid) begin
			for (j = 0; j < 10 && !pend[j]; j++);
			`CHK("vector", 16'h0002 + 16'(2 * j), vec_addr)
			pend[j] = 0;
		end
	end
	function logic [7:0] st(input logic b5);
		return {|pend, 1'b0, b5, 5'h11} | 8'(gie << 2);
	endfunction
	task summarize;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task wr(input logic [7:0] a, d);
		{io_addr, io_wdata, port_write_op} = {a, d, 1'b1};
		cyc(1);
		port_write_op = 0;
		cyc(1);
	endtask
	task rd(input logic [7:0] a, e);
		{io_addr, io_rd} = {a, 1'b1};
		cyc(1);
		io_rd = 0;
		`CHK("read", e, io_rdata)
		cyc(1);
	endtask
	task en(input logic u);
		{unmask_all_instr, mask_all_instr} = u ? 2'b10 : 2'b01;
		cyc(1);
		{unmask_all_instr, mask_all_instr} = 2'b00;
		cyc(1);
	endtask
	// waits out the handler return too, so the next round starts masked
	task drain;
		for (int t = 0; t < 900 && pend != 0; t++)
			cyc(1);
		`CHK("drain", 11'h000, pend)
		if (pend != 0)
			summarize;
		cyc(14);
		en(0);
	endtask
	initial begin
		void'($urandom(28));
		cyc(20);
		rstn = 1;
		cyc(3);
		rd(8'hff, 8'h11);
		rd(8'h20, 8'h00);
		wr(8'h20, 8'hc6);
		wr(8'h21, 8'h07);
		for (i = 0; i < 4; i++) begin
			slow = i[0];
			src_event = 11'($urandom) & 11'h7fe;
			cyc(1);
			pend = src_event & 11'h61e;
			src_event = 0;
			cyc(4);
			rd(8'hff, st(0));
			en(1);
			drain;
		end
		for (m = 0; m < 2; m++) begin
			usb_ps2_mode = m[0];
			wr(8'h20, 8'h00);
			for (k = 0; k < 2; k++) begin
				{usb_se0, ps2_data_low} = (m == k) ? 2'b01 : 2'b10;
				cyc(20);
				{usb_se0, ps2_data_low} = 2'b00;
				cyc(10);
				pend[0] = k[0];
				rd(8'hff, st(k[0]));
			end
			wr(8'hff, 8'h15);
			rd(8'hff, st(0));
			wr(8'h20, 8'h01);
			en(1);
			drain;
		end
		wr(8'hff, 8'h19);
		cyc(3);
		`CHK("suspended", 1'b1, suspended)
		bus_activity = 1;
		cyc(2);
		bus_activity = 0;
		for (k = 0; k < 300 && suspended !== 1'b0; k++)
			cyc(1);
		`CHK("suspended", 1'b0, suspended)
		if (suspended !== 1'b0)
			summarize;
		rd(8'hff, st(0));
		stop_core_op = 1;
		cyc(1);
		stop_core_op = 0;
		cyc(25);
		`CHK("halt", 1'b1, core_halt)
		for (k = 0; k < 4; k++) begin
			{low_supply_reset, supply_dip_reset, dog_timeout_reset} =
				k == 1 ? 3'b100 : k == 3 ? 3'b010 : 3'b001;
			cyc(4);
			{low_supply_reset, supply_dip_reset, dog_timeout_reset} = 3'b000;
			cyc(6);
			gie = 0;
			`CHK("halt", 1'b0, core_halt)
			rd(8'hff, k[0] ? 8'h11 : 8'h51);
			rd(8'h20, 8'h00);
			rd(8'h21, 8'h00);
		end
		summarize;
	end
endmodule
bind irq_ctrl_status_reg irq_ctrl_checker #(.TICK_CYC(TICK_CYC)) irq_ctrl_checker_i (.clock,
	.rstn, .io_addr, .io_wdata, .port_write_op, .instr_end, .return_from_handler_op, .pc_in,
	.carry_flag, .zero_flag, .ack_start, .call_push, .push_word, .vec_valid, .vec_addr,
	.suspended, .restore_en);
`default_nettype wire
